// ===== common/psf_pkg.sv
// Package: message layout, flag positions and types for the status flag readout
package psf_pkg;

  // ----------------------------------------------------------------------
  // Message word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned RW_BIT    = 31;
  localparam int unsigned SEL_HI    = 30;
  localparam int unsigned SEL_LO    = 27;
  localparam int unsigned IDX_HI    = 26;
  localparam int unsigned IDX_LO    = 24;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned IDX_W     = 3;
  localparam int unsigned N_OUTPUT_INDEX    = 8;

  // Read / write marker values
  localparam logic        RW_READ   = 1'h0;
  localparam logic        RESP_RW   = 1'h0;

  // ----------------------------------------------------------------------
  // Message selector codes
  // ----------------------------------------------------------------------
  localparam logic [3:0]  SEL_PROFILE_OUTCOME = 4'hb;
  localparam logic [3:0]  SEL_GLOBAL_FLAGS    = 4'hf;

  // ----------------------------------------------------------------------
  // Flag positions in the response word
  // ----------------------------------------------------------------------
  localparam int unsigned PASS_BIT   = 0;
  localparam int unsigned TMO_BIT    = 1;
  localparam int unsigned ABORT_BIT  = 2;
  localparam int unsigned RSTL_BIT   = 0;
  localparam int unsigned ENL_BIT    = 1;
  localparam int unsigned PSYNC_BIT  = 2;
  localparam int unsigned SUPPLY_BIT = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic        RST_OUTCOME = 1'h0;
  localparam logic        RST_SUPPLY  = 1'h0;
  localparam logic        RST_PSYNC   = 1'h0;
  localparam logic        RST_ENL     = 1'h1;
  localparam logic        RST_RSTL    = 1'h1;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;

  // Synchroniser idle levels: the pins settle here after reset
  localparam logic [2:0]  SYNC_IDLE   = 3'h3;  // {phase_sync, enable, reset_b}
  localparam int unsigned PIN_RSTB    = 0;
  localparam int unsigned PIN_EN      = 1;
  localparam int unsigned PIN_PSYNC   = 2;
  localparam int unsigned N_PIN       = 3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic             rw;
    logic [SEL_W-1:0] message_selector;
    logic [IDX_W-1:0] output_index;
    logic [23:0]      unused;
  } psf_cmd_t;

  typedef struct packed {
    logic abort;
    logic timeout;
    logic pass;
  } psf_outcome_t;

  typedef enum logic [1:0] {
    PSF_IDLE   = 2'h0,
    PSF_DECODE = 2'h1,
    PSF_ANSWER = 2'h3
  } psf_state_t;

endpackage

// ===== core/psf_flag_cell.sv
// Sticky flag cell: set wins over clear, constant reset value
`timescale 1ns/1ps

module psf_flag_cell
  import psf_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
)
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_reg;
  logic flag_next;

  // A set arriving in the clearing cycle survives the clear
  always_comb
  begin
    flag_next = set_i | (flag_reg & ~clr_i);
  end

  // Flag storage
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flag_reg <= RST_VAL;
    else
      flag_reg <= flag_next;
  end

  assign flag_o = flag_reg;

endmodule

// ===== core/psf_readout.sv
// Sticky profile outcome and device-wide flag readout behind the message port
`timescale 1ns/1ps

//
// Contract
// - Selector 1011 with channel reads outcome flags
// - Abort bit 2 set on early gate-off
// - Abort resets 0, cleared by outcome read
// - Time-out bit 1 set on timer expiry
// - Time-out resets 0, cleared by outcome read
// - Pass bit 0 set on timely completion
// - Pass resets 0, cleared by outcome read
// - All zero means nothing finished since read
// - Outcome flags accumulate independently between reads
// - Selector 1111 reads global flags, no channel
// - Supply-high flag bit 3, sticky until read
// - Phase-align flag bit 2, sticky until read
// - Enable latch bit 1 resets to 1
// - Enable latch cleared on read if enabled
// - Enable latch forced 1 while enable low
// - Reset latch bit 0: reset 1, falling edge
module psf_readout
  import psf_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Command word, already assembled by the serial front end
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic [WORD_W-1:0]   cmd_word,
  // Response word for the next frame
  output logic                     resp_valid,
  output logic [WORD_W-1:0]        resp_word,
  // Pulse when a command did not address this block
  output logic                     cmd_foreign,
  // Outcome events from the profile detection engine, one bit per channel
  input  wire logic [N_OUTPUT_INDEX-1:0]   det_pass,
  input  wire logic [N_OUTPUT_INDEX-1:0]   det_timeout,
  input  wire logic [N_OUTPUT_INDEX-1:0]   det_abort,
  // Supervisor level, high while the supply is above its limit
  input  wire logic                supply_high,
  // Asynchronous device pins
  input  wire logic                enable_pin,
  input  wire logic                reset_b_pin,
  input  wire logic                phase_sync_pin
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  psf_state_t            state_reg;
  psf_state_t            state_next;
  psf_cmd_t              cmd_reg;
  logic [N_PIN-1:0]      pin_meta_reg;
  logic [N_PIN-1:0]      pin_sync_reg;
  logic [N_PIN-1:0]      pin_prev_reg;
  logic                  enable_s;
  logic                  rstb_fall;
  logic                  psync_rise;
  logic                  is_profile;
  logic                  is_global;
  logic                  is_read;
  logic                  is_known;
  logic                  in_decode;
  logic                  clr_profile;
  logic                  clr_global;
  logic [N_OUTPUT_INDEX-1:0]     output_index_clr;
  psf_outcome_t          outcome_q [N_OUTPUT_INDEX];
  psf_outcome_t          outcome_sel;
  logic                  supply_q;
  logic                  psync_q;
  logic                  enl_q;
  logic                  rstl_q;
  logic [WORD_W-1:0]     resp_next;
  logic [WORD_W-1:0]     resp_word_reg;
  logic                  foreign_reg;
  logic [WORD_W-1:0]     outcome_word;
  logic [WORD_W-1:0]     global_word;
  logic                  resp_load;
  logic                  foreign_hit;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------

  // Two flops per pin; the first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= SYNC_IDLE;
      pin_sync_reg <= SYNC_IDLE;
    end
    else
    begin
      pin_meta_reg <= {phase_sync_pin, enable_pin, reset_b_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Delayed copy of the settled levels for edge detection
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pin_prev_reg <= SYNC_IDLE;
    else
      pin_prev_reg <= pin_sync_reg;
  end

  // Idle levels after reset avoid a false edge on the first cycles
  assign enable_s   = pin_sync_reg[PIN_EN];
  assign rstb_fall  = pin_prev_reg[PIN_RSTB] & ~pin_sync_reg[PIN_RSTB];
  assign psync_rise = ~pin_prev_reg[PIN_PSYNC] & pin_sync_reg[PIN_PSYNC];

  // ----------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------

  // One command in flight; the source holds cmd_valid while not ready
  assign cmd_ready = (state_reg == PSF_IDLE);

  // Capture the command word on acceptance
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cmd_reg <= psf_cmd_t'(RST_WORD);
    else if (cmd_valid && cmd_ready)
      cmd_reg <= psf_cmd_t'(cmd_word);
  end

  // Selector decode of the held command
  assign is_profile = (cmd_reg.message_selector == SEL_PROFILE_OUTCOME);
  assign is_global  = (cmd_reg.message_selector == SEL_GLOBAL_FLAGS);
  assign is_read    = (cmd_reg.rw == RW_READ);

  // Either readout selector; other selectors belong to other handlers
  assign is_known  = is_profile || is_global;

  // The held command is acted on only in its decode cycle
  assign in_decode = (state_reg == PSF_DECODE);

  // Idle, decode for one cycle, then answer for one cycle on a known selector
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      PSF_IDLE:
      begin
        if (cmd_valid)
          state_next = PSF_DECODE;
      end
      PSF_DECODE:
      begin
        if (is_known)
          state_next = PSF_ANSWER;
        else
          state_next = PSF_IDLE;
      end
      PSF_ANSWER:
      begin
        state_next = PSF_IDLE;
      end
      default:
      begin
        state_next = PSF_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_reg <= PSF_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------------
  // Read-clear strobes
  // ----------------------------------------------------------------------

  // Writes get the same answer but leave the flags standing
  assign clr_profile = in_decode && is_profile && is_read;
  assign clr_global  = in_decode && is_global && is_read;

  // Only the addressed channel loses its flags
  always_comb
  begin
    output_index_clr = '0;
    if (clr_profile)
      output_index_clr[cmd_reg.output_index] = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Per-channel outcome flags
  // ----------------------------------------------------------------------

  // Three independent sticky cells per channel
  for (genvar ch = 0; ch < N_OUTPUT_INDEX; ch++)
  begin : g_output_index
    psf_flag_cell #(.RST_VAL(RST_OUTCOME)) u_abort
    (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .set_i  (det_abort[ch]),
      .clr_i  (output_index_clr[ch]),
      .flag_o (outcome_q[ch].abort)
    );

    psf_flag_cell #(.RST_VAL(RST_OUTCOME)) u_timeout
    (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .set_i  (det_timeout[ch]),
      .clr_i  (output_index_clr[ch]),
      .flag_o (outcome_q[ch].timeout)
    );

    psf_flag_cell #(.RST_VAL(RST_OUTCOME)) u_pass
    (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .set_i  (det_pass[ch]),
      .clr_i  (output_index_clr[ch]),
      .flag_o (outcome_q[ch].pass)
    );
  end

  // ----------------------------------------------------------------------
  // Device-wide flags
  // ----------------------------------------------------------------------

  // Supply level keeps the flag set for as long as it stays high
  psf_flag_cell #(.RST_VAL(RST_SUPPLY)) u_supply
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set_i  (supply_high),
    .clr_i  (clr_global),
    .flag_o (supply_q)
  );

  // Each rising edge of the phase pin counts as one occurrence
  psf_flag_cell #(.RST_VAL(RST_PSYNC)) u_psync
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set_i  (psync_rise),
    .clr_i  (clr_global),
    .flag_o (psync_q)
  );

  // Low enable overrides any clear; a read only clears while enabled
  psf_flag_cell #(.RST_VAL(RST_ENL)) u_enable_latch
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set_i  (~enable_s),
    .clr_i  (clr_global & enable_s),
    .flag_o (enl_q)
  );

  // Falling reset pin sets; a reset held low is seen only at its edge
  psf_flag_cell #(.RST_VAL(RST_RSTL)) u_reset_latch
  (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .set_i  (rstb_fall),
    .clr_i  (clr_global),
    .flag_o (rstl_q)
  );

  // ----------------------------------------------------------------------
  // Response assembly
  // ----------------------------------------------------------------------

  // Flags of the addressed channel
  assign outcome_sel = outcome_q[cmd_reg.output_index];

  // ----------------------------------------------------------------------
  // Payload views
  // ----------------------------------------------------------------------

  // Outcome payload and index of the addressed channel, every other bit zero
  always_comb
  begin
    outcome_word = RST_WORD;
    outcome_word[IDX_HI:IDX_LO] = cmd_reg.output_index;
    outcome_word[ABORT_BIT] = outcome_sel.abort;
    outcome_word[TMO_BIT]   = outcome_sel.timeout;
    outcome_word[PASS_BIT]  = outcome_sel.pass;
  end

  // Device-wide payload; this message carries no channel field
  always_comb
  begin
    global_word = RST_WORD;
    global_word[SUPPLY_BIT] = supply_q;
    global_word[PSYNC_BIT]  = psync_q;
    global_word[ENL_BIT]    = enl_q;
    global_word[RSTL_BIT]   = rstl_q;
  end

  // ----------------------------------------------------------------------
  // Response register
  // ----------------------------------------------------------------------

  // Word built from the pre-clear values so no event is lost
  always_comb
  begin
    resp_next = RST_WORD;
    if (is_profile)
      resp_next = outcome_word;
    else if (is_global)
      resp_next = global_word;
    resp_next[RW_BIT] = RESP_RW;
    resp_next[SEL_HI:SEL_LO] = cmd_reg.message_selector;
  end

  // Load and foreign strobes, both decided in the decode cycle only
  assign resp_load   = in_decode && is_known;
  assign foreign_hit = in_decode && !is_known;

  // Response word holds until the next answered command;
  // a foreign command leaves the last answer in place
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      resp_word_reg <= RST_WORD;
    else if (resp_load)
      resp_word_reg <= resp_next;
  end

  // Foreign-command pulse, for the message router
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      foreign_reg <= 1'b0;
    else
      foreign_reg <= foreign_hit;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  assign resp_valid  = (state_reg == PSF_ANSWER);
  assign resp_word   = resp_word_reg;
  assign cmd_foreign = foreign_reg;

endmodule

// ===== sim/psf_host.sv
// Host model: offers one command word and collects the answer
`timescale 1ns/1ps

module psf_host
  import psf_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              req,
  input  wire logic [WORD_W-1:0] req_word,
  output logic                   cmd_valid = 1'b0,
  input  wire logic              cmd_ready,
  output logic [WORD_W-1:0]      cmd_word = 32'h0000_0000,
  input  wire logic              resp_valid,
  input  wire logic [WORD_W-1:0] resp_word,
  input  wire logic              cmd_foreign,
  output logic [WORD_W-1:0]      got = 32'h0000_0000,
  output logic                   fgn = 1'b0,
  output logic                   done = 1'b0
);
  logic busy = 1'b0;

  // ----------------------------------------------------------------
  // Offer, hold until taken, then wait for the answer
  // ----------------------------------------------------------------
  // The word is inverted once taken so a stale word is never mistaken
  always @(posedge mclk)
  begin
    done <= 1'b0;
    if (!rst_n)
    begin
      cmd_valid <= 1'b0;
      busy      <= 1'b0;
    end
    else if (req && !busy)
    begin
      cmd_valid <= 1'b1;
      cmd_word  <= req_word;
      busy      <= 1'b1;
    end
    else if (cmd_valid && cmd_ready)
    begin
      cmd_valid <= 1'b0;
      cmd_word  <= ~cmd_word;
    end
    else if (busy && !cmd_valid && (resp_valid || cmd_foreign))
    begin
      got  <= resp_word;
      fgn  <= cmd_foreign;
      done <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

// ===== sim/psf_readout_asserts.sv
// Checker: port timing and response layout of the flag readout
`timescale 1ns/1ps

module psf_readout_asserts
  import psf_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic [WORD_W-1:0] cmd_word,
  input wire logic              resp_valid,
  input wire logic [WORD_W-1:0] resp_word,
  input wire logic              cmd_foreign,
  input wire logic [N_OUTPUT_INDEX-1:0] det_pass,
  input wire logic [N_OUTPUT_INDEX-1:0] det_timeout,
  input wire logic [N_OUTPUT_INDEX-1:0] det_abort,
  input wire logic              supply_high,
  input wire logic              enable_pin,
  input wire logic              reset_b_pin,
  input wire logic              phase_sync_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic              take;
  logic              known;
  logic [WORD_W-1:0] held_word;
  logic [3:0]        en_low_cnt;
  assign take  = cmd_valid && cmd_ready;
  assign known = cmd_word[30:27] == SEL_PROFILE_OUTCOME || cmd_word[30:27] == SEL_GLOBAL_FLAGS;

  // Last taken word, so the answer can be tied to its own command
  always_ff @(posedge mclk)
    if (!rst_n)
      held_word <= 32'h0000_0000;
    else if (take)
      held_word <= cmd_word;

  // Saturating count of cycles with the enable pin low
  always_ff @(posedge mclk)
    if (!rst_n || enable_pin)
      en_low_cnt <= 4'h0;
    else if (en_low_cnt != 4'hf)
      en_low_cnt <= en_low_cnt + 4'h1;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_answer_two_cycles: assert property (take && known |-> ##2 resp_valid && !cmd_foreign)
    else $error("known selector not answered two cycles after take");
  a_foreign_two_cycles: assert property (take && !known |-> ##2 cmd_foreign && !resp_valid)
    else $error("unknown selector not flagged two cycles after take");
  a_busy_window: assert property (take && known |=> !cmd_ready [*2] ##1 cmd_ready)
    else $error("ready not low for exactly two cycles after a known take");
  a_foreign_ready: assert property (take && !known |=> !cmd_ready ##1 cmd_ready)
    else $error("ready not back one cycle after a foreign take");
  a_resp_rw_zero: assert property (resp_valid |-> !resp_word[RW_BIT])
    else $error("response top bit not zero");
  a_outcome_echo: assert property (resp_valid && held_word[30:27] == SEL_PROFILE_OUTCOME
    |-> resp_word[30:24] == held_word[30:24] && resp_word[23:3] == 21'h0)
    else $error("outcome response does not echo command or has stray bits");
  a_global_layout: assert property (resp_valid && held_word[30:27] == SEL_GLOBAL_FLAGS
    |-> resp_word[30:4] == {SEL_GLOBAL_FLAGS, 23'h0})
    else $error("global response layout wrong");
  a_enable_forced: assert property (resp_valid && held_word[30:27] == SEL_GLOBAL_FLAGS
    && en_low_cnt >= 4'h8 |-> resp_word[ENL_BIT])
    else $error("enable latch not one while enable pin low");
  a_word_holds: assert property ($changed(resp_word) |-> resp_valid)
    else $error("response word changed without an answer");
endmodule

bind psf_readout psf_readout_asserts u_chk (.mclk(mclk), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
  .resp_valid(resp_valid), .resp_word(resp_word), .cmd_foreign(cmd_foreign),
  .det_pass(det_pass), .det_timeout(det_timeout), .det_abort(det_abort),
  .supply_high(supply_high), .enable_pin(enable_pin), .reset_b_pin(reset_b_pin),
  .phase_sync_pin(phase_sync_pin));

// ===== sim/tb.sv
// Testbench: sticky outcome and device-wide flag readout
`timescale 1ns/1ps

module tb;
  import psf_pkg::*;
  typedef struct packed
  {
    logic [7:0]  p;
    logic [7:0]  t;
    logic [7:0]  a;
    logic        s;
    logic [31:0] cmd;
    logic [31:0] exp;
  } psf_row_t;

  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              req = 1'b0;
  logic [WORD_W-1:0] req_word = 32'h0000_0000;
  logic              cmd_valid;
  logic              cmd_ready;
  logic [WORD_W-1:0] cmd_word;
  logic              resp_valid;
  logic [WORD_W-1:0] resp_word;
  logic              cmd_foreign;
  logic [N_OUTPUT_INDEX-1:0] det_pass = 8'h00;
  logic [N_OUTPUT_INDEX-1:0] det_timeout = 8'h00;
  logic [N_OUTPUT_INDEX-1:0] det_abort = 8'h00;
  logic              supply_high = 1'b0;
  logic              enable_pin = 1'b1;
  logic              reset_b_pin = 1'b1;
  logic              phase_sync_pin = 1'b0;
  logic [WORD_W-1:0] got;
  logic              fgn;
  logic              done;
  int                error_cnt = 0;
  int                cmp_count = 0;

  // Ordinary cases: events on the left, read command and answer on the right
  psf_row_t rows [9] = '{
    '{8'h01, 8'h00, 8'h00, 1'b0, 32'h5800_0000, 32'h5800_0001},
    '{8'h00, 8'h20, 8'h00, 1'b0, 32'h5d00_0000, 32'h5d00_0002},
    '{8'h00, 8'h00, 8'h80, 1'b0, 32'h5f00_0000, 32'h5f00_0004},
    '{8'h08, 8'h08, 8'h08, 1'b0, 32'h5b00_0000, 32'h5b00_0007},
    '{8'h00, 8'h00, 8'h00, 1'b0, 32'h5b00_0000, 32'h5b00_0000},
    '{8'h00, 8'h00, 8'h40, 1'b0, 32'h5a00_0000, 32'h5a00_0000},
    '{8'h00, 8'h00, 8'h00, 1'b0, 32'h5e00_0000, 32'h5e00_0004},
    '{8'h00, 8'h00, 8'h00, 1'b1, 32'h7800_0000, 32'h7800_000b},
    '{8'h00, 8'h00, 8'h00, 1'b0, 32'h7800_0000, 32'h7800_0000}};

  always #25 mclk = ~mclk;

  psf_host u_host (.mclk(mclk), .rst_n(rst_n), .req(req), .req_word(req_word),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
    .resp_valid(resp_valid), .resp_word(resp_word), .cmd_foreign(cmd_foreign),
    .got(got), .fgn(fgn), .done(done));

  psf_readout DUT (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_word(cmd_word), .resp_valid(resp_valid),
    .resp_word(resp_word), .cmd_foreign(cmd_foreign), .det_pass(det_pass),
    .det_timeout(det_timeout), .det_abort(det_abort), .supply_high(supply_high),
    .enable_pin(enable_pin), .reset_b_pin(reset_b_pin), .phase_sync_pin(phase_sync_pin));

  // ----------------------------------------------------------------
  // Compare, report and transfer tasks
  // ----------------------------------------------------------------
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One command through the host; a lost answer ends the run
  task automatic send(input logic [31:0] w, input logic [31:0] e, input logic ef);
    int n;
    @(negedge mclk);
    req      = 1'b1;
    req_word = w;
    @(negedge mclk);
    req = 1'b0;
    n   = 0;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40)
    begin
      error_cnt++;
      close_out();
    end
    else
    begin
      chk1(fgn, ef);
      if (!ef)
        chk32(got, e);
    end
  endtask

  // One-cycle event pulse; pins need a few cycles through the synchronisers
  task automatic pulse(input psf_row_t r);
    @(negedge mclk);
    {det_pass, det_timeout, det_abort, supply_high} = {r.p, r.t, r.a, r.s};
    @(negedge mclk);
    {det_pass, det_timeout, det_abort, supply_high} = 25'h0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    chk32(resp_word, RST_WORD);
    chk1(cmd_ready, 1'b1);
    foreach (rows[i])
    begin
      pulse(rows[i]);
      send(rows[i].cmd, rows[i].exp, 1'b0);
    end
    phase_sync_pin = 1'b1;
    repeat (8) @(negedge mclk);
    send(32'h7800_0000, 32'h7800_0004, 1'b0);
    phase_sync_pin = 1'b0;
    enable_pin     = 1'b0;
    repeat (8) @(negedge mclk);
    send(32'h7800_0000, 32'h7800_0002, 1'b0);
    enable_pin = 1'b1;
    repeat (8) @(negedge mclk);
    send(32'h7800_0000, 32'h7800_0002, 1'b0);
    send(32'h7800_0000, 32'h7800_0000, 1'b0);
    reset_b_pin = 1'b0;
    repeat (8) @(negedge mclk);
    send(32'h7800_0000, 32'h7800_0001, 1'b0);
    reset_b_pin = 1'b1;
    repeat (8) @(negedge mclk);
    send(32'h7800_0000, 32'h7800_0000, 1'b0);
    // A write answers like a read but must leave the flags standing
    pulse('{8'h02, 8'h00, 8'h00, 1'b0, 32'h0, 32'h0});
    send(32'hd900_0000, 32'h5900_0001, 1'b0);
    send(32'h5900_0000, 32'h5900_0001, 1'b0);
    send(32'h5900_0000, 32'h5900_0000, 1'b0);
    send(32'h5000_0000, 32'h0, 1'b1);
    // Event in the clearing cycle itself: this answer misses it, the next read shows it
    fork
      send(32'h5c00_0000, 32'h5c00_0000, 1'b0);
      begin
        repeat (3) @(negedge mclk);
        det_pass = 8'h10;
        @(negedge mclk);
        det_pass = 8'h00;
      end
    join
    send(32'h5c00_0000, 32'h5c00_0001, 1'b0);
    // Second reset in mid-run brings every flag back to its reset value
    pulse('{8'h01, 8'h01, 8'h01, 1'b1, 32'h0, 32'h0});
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    send(32'h7800_0000, 32'h7800_0003, 1'b0);
    send(32'h5800_0000, 32'h5800_0000, 1'b0);
    close_out();
  end
endmodule
